// [sld_top.v]
`timescale 1ns/1ns
`include "sld_map.vh"

module sld_top #(
	parameter NPORT = 8,
	parameter NPIN = 8,
	parameter NCOM = 8,
	parameter [31:0] IDENT = `SLD_IDENT_VAL
) (
	input wire clk,
	input wire rst_n,
	input wire slow_32k_clock,
	input wire deep_sleep,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	output reg [31:0] hrdata_q,
	output reg hready_q,
	output reg hresp_q,
	output reg [NCOM-1:0] com_q,
	output reg [NPORT*NPIN-1:0] seg_q
);

	localparam NSEG = NPORT * NPIN;

	// Display data: entry p is low commons, NPORT+p high commons
	reg [31:0] data_mem [0:2*NPORT-1];
	reg [31:0] divider_q;
	reg [`SLD_CTL_WIDTH-1:0] ctl_sw_q;
	reg [`SLD_CTL_WIDTH-1:0] ctl_q;
	reg [11:0] wr_addr_q;
	reg wr_pend_q;
	reg slow_s1_q;
	reg slow_s2_q;
	reg slow_s3_q;
	reg [NCOM-1:0] com_d;
	reg [NSEG-1:0] seg_d;
	reg [31:0] rdata_d;
	reg addr_ok;
	wire slow_tick;
	wire take;
	wire type_b;
	wire [2:0] com_last;
	wire [1:0] drive_operation_select;
	wire [1:0] bias;
	wire sel_hs;
	wire [1:0] eff_op;
	wire [1:0] pwm_last;
	wire hs_run;
	wire ls_run;
	wire [3:0] hs_sub;
	wire [3:0] ls_sub;
	wire [1:0] hs_qtr;
	wire [1:0] ls_qtr;
	wire [1:0] hs_pwm;
	wire [1:0] ls_pwm;
	wire hs_dead;
	wire ls_dead;
	wire hs_fend;
	wire ls_fend;
	wire [3:0] sub;
	wire [1:0] qtr;
	wire [1:0] pwm;
	wire dead;
	wire fend;
	wire [3:0] m_cnt;
	wire half_b;
	wire [2:0] cur_com;
	wire phase;
	wire [2:0] lvl_b;
	integer k;

	// Address decode shared by read and write: index of data word
	function [3:0] data_index;
		input [11:0] a;
		begin
			data_index = {(a & `SLD_BANK_MASK) == `SLD_OFS_DATA_HI,
				a[`SLD_PORT_MSB:`SLD_PORT_LSB]};
		end
	endfunction

	// True when the address hits a data word
	function is_data;
		input [11:0] a;
		begin
			is_data = ((a & `SLD_BANK_MASK) == `SLD_OFS_DATA_LO) ||
				((a & `SLD_BANK_MASK) == `SLD_OFS_DATA_HI);
		end
	endfunction

	// Pin high while the PWM step is below level L of B
	function pwm_on;
		input [1:0] step;
		input [2:0] lvl;
		begin
			pwm_on = {1'b0, step} < lvl;
		end
	endfunction

	// Shared control fields, applied copy
	assign type_b = ctl_q[`SLD_CTL_TYPE_B];
	assign com_last = ctl_q[`SLD_CTL_COM_MSB:`SLD_CTL_COM_LSB];
	assign drive_operation_select = ctl_q[`SLD_CTL_OP_MSB:`SLD_CTL_OP_LSB];
	assign bias = ctl_q[`SLD_CTL_BIAS_MSB:`SLD_CTL_BIAS_LSB];
	assign sel_hs = ctl_q[`SLD_CTL_SEL_HS];

	// Quarter bias is not offered by the slow generator
	assign eff_op = (!sel_hs && drive_operation_select == `SLD_OP_PWM &&
		bias == `SLD_BIAS_QUARTER) ? `SLD_OP_OFF : drive_operation_select;
	assign pwm_last = bias + 2'h1;
	assign lvl_b = {1'b0, bias} + 3'h2;

	// Only the selected generator runs; the fast one sleeps in deep sleep
	assign hs_run = sel_hs && eff_op != `SLD_OP_OFF && !deep_sleep;
	assign ls_run = !sel_hs && eff_op != `SLD_OP_OFF;

	// 32 kHz input: two-stage synchroniser, then edge detect on stage two
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slow_s1_q <= 1'b0;
			slow_s2_q <= 1'b0;
			slow_s3_q <= 1'b0;
		end else begin
			slow_s1_q <= slow_32k_clock;
			slow_s2_q <= slow_s1_q;
			slow_s3_q <= slow_s2_q;
		end
	end
	assign slow_tick = slow_s2_q & ~slow_s3_q;

	// Fast generator ticks on every system clock
	sld_gen #(
		.CW(`SLD_HS_CNT_W)
	) u_hs_gen (
		.clk(clk),
		.rst_n(rst_n),
		.tick(1'b1),
		.run(hs_run),
		.sub_div(divider_q[`SLD_DIV_SUB_MSB:`SLD_DIV_SUB_LSB]),
		.dead_div(divider_q[`SLD_DIV_DEAD_MSB:`SLD_DIV_DEAD_LSB]),
		.com_last(com_last),
		.type_b(type_b),
		.pwm_last(pwm_last),
		.sub_q(hs_sub),
		.qtr_q(hs_qtr),
		.pwm_q(hs_pwm),
		.dead_q(hs_dead),
		.fend_q(hs_fend)
	);

	// Slow generator ticks on the 32 kHz edge, low divider bits only
	sld_gen #(
		.CW(`SLD_LS_CNT_W)
	) u_ls_gen (
		.clk(clk),
		.rst_n(rst_n),
		.tick(slow_tick),
		.run(ls_run),
		.sub_div(divider_q[`SLD_DIV_SUB_LSB+`SLD_LS_CNT_W-1:
			`SLD_DIV_SUB_LSB]),
		.dead_div(divider_q[`SLD_DIV_DEAD_LSB+`SLD_LS_CNT_W-1:
			`SLD_DIV_DEAD_LSB]),
		.com_last(com_last),
		.type_b(type_b),
		.pwm_last(pwm_last),
		.sub_q(ls_sub),
		.qtr_q(ls_qtr),
		.pwm_q(ls_pwm),
		.dead_q(ls_dead),
		.fend_q(ls_fend)
	);

	// Output multiplexer picks the configured generator
	assign sub = sel_hs ? hs_sub : ls_sub;
	assign qtr = sel_hs ? hs_qtr : ls_qtr;
	assign pwm = sel_hs ? hs_pwm : ls_pwm;
	assign dead = sel_hs ? hs_dead : ls_dead;
	assign fend = sel_hs ? hs_fend : ls_fend;

	// Current common and polarity; Type B second half inverts
	assign m_cnt = {1'b0, com_last} + 4'h1;
	assign half_b = type_b && (sub >= m_cnt);
	assign cur_com = half_b ? sub[2:0] - com_last - 3'h1 : sub[2:0];
	assign phase = qtr[1] ^ half_b;

	// Bus side: one-cycle accept, zero wait states, always OKAY
	assign take = hsel && htrans[1];

	// Read data prepared in the address phase, answered in data phase
	always @* begin
		rdata_d = 32'h00000000;
		addr_ok = 1'b1;
		if (haddr == `SLD_OFS_IDENT) begin
			rdata_d = IDENT;
		end else if (haddr == `SLD_OFS_DIVIDER) begin
			rdata_d = divider_q;
		end else if (haddr == `SLD_OFS_CONTROL) begin
			rdata_d = {{(32-`SLD_CTL_WIDTH){1'b0}}, ctl_sw_q};
		end else if (is_data(haddr)) begin
			rdata_d = data_mem[data_index(haddr)];
		end else begin
			addr_ok = 1'b0;
		end
	end

	// Bus registers: address phase capture, data phase write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_q <= 32'h00000000;
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 12'h000;
			divider_q <= `SLD_DIVIDER_RST;
			ctl_sw_q <= `SLD_CONTROL_RST;
		end else begin
			hready_q <= 1'b1;
			hresp_q <= 1'b0;
			wr_pend_q <= take && hwrite;
			wr_addr_q <= haddr;
			if (take && !hwrite) begin
				hrdata_q <= addr_ok ? rdata_d : 32'h00000000;
			end
			if (wr_pend_q) begin
				if (wr_addr_q == `SLD_OFS_DIVIDER) begin
					divider_q <= hwdata;
				end else if (wr_addr_q == `SLD_OFS_CONTROL) begin
					ctl_sw_q <= hwdata[`SLD_CTL_WIDTH-1:0];
				end
			end
		end
	end

	// Display data words, written whole in the data phase
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (k = 0; k < 2 * NPORT; k = k + 1) begin
				data_mem[k] <= 32'h00000000;
			end
		end else if (wr_pend_q && is_data(wr_addr_q)) begin
			data_mem[data_index(wr_addr_q)] <= hwdata;
		end
	end

	// Control settings reach the generators only at a frame end or while stopped; divider writes apply at once
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= `SLD_CONTROL_RST;
		end else if (fend || !(hs_run || ls_run)) begin
			ctl_q <= ctl_sw_q;
		end
	end

	// Common drive for each common electrode
	genvar gc;
	generate
		for (gc = 0; gc < NCOM; gc = gc + 1) begin : g_com
			always @* begin
				com_d[gc] = 1'b0;
				if (!(hs_run || ls_run) || gc > com_last) begin
					com_d[gc] = 1'b0;
				end else if (dead) begin
					com_d[gc] = 1'b1;
				end else if (eff_op == `SLD_OP_CORR) begin
					// Inactive commons run at the same rate, one quarter step ahead
					com_d[gc] = (gc == cur_com) ? phase :
						phase ^ qtr[0];
				end else if (gc == cur_com) begin
					com_d[gc] = pwm_on(pwm, phase ? lvl_b : 3'h0);
				end else begin
					com_d[gc] = pwm_on(pwm, phase ? 3'h1 :
						lvl_b - 3'h1);
				end
			end
		end
	endgenerate

	// Per-pin logic: pick this pin's bit for the current common
	genvar gs;
	generate
		for (gs = 0; gs < NSEG; gs = gs + 1) begin : g_seg
			wire [31:0] word_lo;
			wire [31:0] word_hi;
			wire [3:0] nib;
			wire on_bit;
			assign word_lo = data_mem[gs / NPIN];
			assign word_hi = data_mem[NPORT + gs / NPIN];
			assign nib = cur_com[2] ?
				word_hi[(gs % NPIN) * 4 +: 4] :
				word_lo[(gs % NPIN) * 4 +: 4];
			assign on_bit = nib[cur_com[1:0]];
			always @* begin
				seg_d[gs] = 1'b0;
				if (!(hs_run || ls_run)) begin
					seg_d[gs] = 1'b0;
				end else if (dead) begin
					seg_d[gs] = 1'b1;
				end else if (eff_op == `SLD_OP_CORR) begin
					seg_d[gs] = on_bit ? ~phase : phase;
				end else if (on_bit) begin
					seg_d[gs] = pwm_on(pwm, phase ? 3'h0 : lvl_b);
				end else begin
					seg_d[gs] = pwm_on(pwm, phase ? lvl_b - 3'h1 :
						3'h1);
				end
			end
		end
	endgenerate

	// Pin outputs registered
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			com_q <= {NCOM{1'b0}};
			seg_q <= {NSEG{1'b0}};
		end else begin
			com_q <= com_d;
			seg_q <= seg_d;
		end
	end

endmodule // sld_top

// [sld_map.vh]
`ifndef SLD_MAP_VH
`define SLD_MAP_VH

// Byte offsets of the register map
`define SLD_OFS_IDENT 12'h000
`define SLD_OFS_DIVIDER 12'h004
`define SLD_OFS_CONTROL 12'h008
`define SLD_OFS_DATA_LO 12'h100
`define SLD_OFS_DATA_HI 12'h200
`define SLD_PORT_LSB 2
`define SLD_PORT_MSB 4
`define SLD_BANK_MASK 12'hFE3

// Arbitrary identification value, revision in the low byte
`define SLD_IDENT_VAL 32'h00AB0001

// Divider register fields
`define SLD_DIV_SUB_LSB 0
`define SLD_DIV_SUB_MSB 15
`define SLD_DIV_DEAD_LSB 16
`define SLD_DIV_DEAD_MSB 31
`define SLD_DIVIDER_RST 32'h00000000

// Control register fields
`define SLD_CTL_TYPE_B 0
`define SLD_CTL_COM_LSB 1
`define SLD_CTL_COM_MSB 3
`define SLD_CTL_OP_LSB 4
`define SLD_CTL_OP_MSB 5
`define SLD_CTL_BIAS_LSB 6
`define SLD_CTL_BIAS_MSB 7
`define SLD_CTL_SEL_HS 8
`define SLD_CTL_WIDTH 9
`define SLD_CONTROL_RST 9'h000

// Operating modes and bias codes
`define SLD_OP_OFF 2'h0
`define SLD_OP_PWM 2'h1
`define SLD_OP_CORR 2'h2
`define SLD_BIAS_HALF 2'h0
`define SLD_BIAS_THIRD 2'h1
`define SLD_BIAS_QUARTER 2'h2

// Quarter steps of a sub-frame and commons per data word
`define SLD_QTR_LAST 2'h3
`define SLD_COMS_PER_WORD 4
`define SLD_LS_CNT_W 8
`define SLD_HS_CNT_W 16

`endif

// [sld_gen.v]
`timescale 1ns/1ns
`include "sld_map.vh"

// Waveform generator: sub-frame, quarter, PWM and dead-time timing
module sld_gen #(
	parameter CW = 16
) (
	input wire clk,
	input wire rst_n,
	input wire tick,
	input wire run,
	input wire [CW-1:0] sub_div,
	input wire [CW-1:0] dead_div,
	input wire [2:0] com_last,
	input wire type_b,
	input wire [1:0] pwm_last,
	output reg [3:0] sub_q,
	output reg [1:0] qtr_q,
	output reg [1:0] pwm_q,
	output reg dead_q,
	output reg fend_q
);

	reg [CW-1:0] div_q;
	reg [CW-1:0] dcnt_q;
	wire [3:0] sub_last;

	// Type B doubles the sub-frames of a frame
	assign sub_last = type_b ? {com_last, 1'b1} : {1'b0, com_last};

	// Counters advance only on this generator's clock tick
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= {CW{1'b0}};
			dcnt_q <= {CW{1'b0}};
			sub_q <= 4'h0;
			qtr_q <= 2'h0;
			pwm_q <= 2'h0;
			dead_q <= 1'b0;
			fend_q <= 1'b0;
		end else if (!run) begin
			div_q <= sub_div;
			dcnt_q <= {CW{1'b0}};
			sub_q <= 4'h0;
			qtr_q <= 2'h0;
			pwm_q <= 2'h0;
			dead_q <= 1'b0;
			fend_q <= 1'b0;
		end else begin
			fend_q <= 1'b0;
			if (tick) begin
				// PWM step counter wraps at the bias count
				pwm_q <= (pwm_q >= pwm_last) ? 2'h0 : pwm_q + 2'h1;
				if (dead_q) begin
					// Dead time runs from its own counter
					if (dcnt_q == {CW{1'b0}}) begin
						dead_q <= 1'b0;
						div_q <= sub_div;
					end else begin
						dcnt_q <= dcnt_q - {{(CW-1){1'b0}}, 1'b1};
					end
				end else if (div_q != {CW{1'b0}}) begin
					div_q <= div_q - {{(CW-1){1'b0}}, 1'b1};
				end else begin
					// Quarter ends: C+1 ticks each, four per sub-frame
					div_q <= sub_div;
					qtr_q <= qtr_q + 2'h1;
					if (qtr_q == `SLD_QTR_LAST) begin
						if (sub_q >= sub_last) begin
							sub_q <= 4'h0;
							fend_q <= 1'b1;
							// Contrast dead time follows every frame when dead_div is nonzero
							if (dead_div != {CW{1'b0}}) begin
								dead_q <= 1'b1;
								dcnt_q <= dead_div - {{(CW-1){1'b0}}, 1'b1};
							end
						end else begin
							sub_q <= sub_q + 4'h1;
						end
					end
				end
			end
		end
	end

endmodule // sld_gen

// [sld_top_monitor.sv]
`timescale 1ns/1ns
`include "sld_map.vh"

// Port checker for the drive top
module sld_mon #(
	parameter [31:0] IDENT = `SLD_IDENT_VAL
) (
	input wire clk,
	input wire rst_n,
	input wire deep_sleep,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata_q,
	input wire hready_q,
	input wire hresp_q,
	input wire [7:0] com_q,
	input wire [63:0] seg_q
);
	reg wr_q;
	reg [11:0] wa_q;
	reg [31:0] div_q;
	reg [8:0] ctl_q;
	reg [10:0] idle_q;
	wire rd = hsel && htrans[1] && !hwrite;
	wire pins0 = com_q == 8'h00 && seg_q == 64'h0;

	// Shadow divider and control, committed in the write data phase
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			wa_q <= 12'h000;
			div_q <= `SLD_DIVIDER_RST;
			ctl_q <= `SLD_CONTROL_RST;
			idle_q <= 11'h000;
		end else begin
			wr_q <= hsel && htrans[1] && hwrite;
			wa_q <= haddr;
			if (wr_q && wa_q == `SLD_OFS_DIVIDER)
				div_q <= hwdata;
			if (wr_q && wa_q == `SLD_OFS_CONTROL) begin
				ctl_q <= hwdata[8:0];
				idle_q <= 11'h000;
			end else if (idle_q != 11'h4B0) // Outlasts the longest frame the test runs
				idle_q <= idle_q + 11'h001;
		end
	end

	AST_READY: assert property (@(posedge clk) disable iff (!rst_n)
		hready_q) else $error("bus not ready");
	AST_OKAY: assert property (@(posedge clk) disable iff (!rst_n)
		rd |=> !hresp_q) else $error("error response");
	AST_IDENT: assert property (@(posedge clk) disable iff (!rst_n)
		rd && haddr == `SLD_OFS_IDENT |=> hrdata_q == IDENT)
		else $error("ident value wrong");
	AST_UNMAP: assert property (@(posedge clk) disable iff (!rst_n)
		rd && haddr == 12'h00C |=> hrdata_q == 32'h0)
		else $error("unmapped read not zero");
	AST_STAND: assert property (@(posedge clk) disable iff (!rst_n)
		!rd |=> $stable(hrdata_q)) else $error("read data moved");
	AST_DIV: assert property (@(posedge clk) disable iff (!rst_n)
		rd && haddr == `SLD_OFS_DIVIDER |=> hrdata_q == $past(div_q))
		else $error("divider readback wrong");
	AST_DEEP: assert property (@(posedge clk) disable iff (!rst_n)
		(deep_sleep && ctl_q[8]) [*5] |-> pins0)
		else $error("fast generator ran in deep sleep");
	AST_OFF: assert property (@(posedge clk) disable iff (!rst_n)
		idle_q == 11'h4B0 && ctl_q[5:4] == `SLD_OP_OFF |-> pins0)
		else $error("pins active in off mode");
endmodule // sld_mon

bind sld_top sld_mon #(.IDENT(IDENT)) u_mon (
	.clk(clk), .rst_n(rst_n), .deep_sleep(deep_sleep), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hrdata_q(hrdata_q), .hready_q(hready_q), .hresp_q(hresp_q),
	.com_q(com_q), .seg_q(seg_q)
);

// [sld_glass.sv]
`timescale 1ns/1ns

// Glass stand-in: tallies electrode levels for window checks
module sld_glass (
	input wire clk,
	input wire [7:0] com,
	input wire [63:0] seg,
	output reg [31:0] n_both,
	output reg [31:0] n_diff,
	output reg [31:0] n_ones
);
	// Counters start clear
	initial begin
		n_both = 32'h0;
		n_diff = 32'h0;
		n_ones = 32'h0;
	end

	// Both-high cells, pin 1 phase against common 0, common 1 duty
	always @(posedge clk) begin
		n_both <= n_both + {31'h0, com[0] & seg[0]};
		n_diff <= n_diff + {31'h0, seg[1] ^ com[0]};
		n_ones <= n_ones + {31'h0, com[1]};
	end
endmodule // sld_glass

// [segment_lcd_direct_drive_test.sv]
`timescale 1ns/1ns
`include "sld_map.vh"

// Register and waveform tests of the drive top
module segment_lcd_direct_drive_test;
	reg clk;
	reg rst_n;
	reg sclk;
	reg ds;
	reg hsel;
	reg [11:0] haddr;
	reg [1:0] htrans;
	reg hwrite;
	reg [31:0] hwdata;
	wire [31:0] hrdata_q;
	wire hready_q;
	wire hresp_q;
	wire [7:0] com_q;
	wire [63:0] seg_q;
	wire [31:0] n_both;
	wire [31:0] n_diff;
	wire [31:0] n_ones;
	reg [31:0] rdat;
	reg [31:0] n;
	reg [31:0] b;
	reg [31:0] d;
	reg [11:0] p;
	integer n_fail;
	integer n_checks;

	sld_top u_dut (
		.clk(clk), .rst_n(rst_n), .slow_32k_clock(sclk), .deep_sleep(ds),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hrdata_q(hrdata_q),
		.hready_q(hready_q), .hresp_q(hresp_q), .com_q(com_q), .seg_q(seg_q)
	);
	sld_glass u_glass (.clk(clk), .com(com_q), .seg(seg_q),
		.n_both(n_both), .n_diff(n_diff), .n_ones(n_ones));

	// 125 MHz system clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Slow tick source, one rising edge per 20 system cycles
	initial begin
		sclk = 1'b0;
		#3;
		forever #80 sclk = ~sclk;
	end

	task print_verdict;
		begin
			$display("checks %0d fails %0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				n_fail = n_fail + 1;
				$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// One zero-wait transfer: address phase, then data phase
	task bus(input w, input [11:0] a, input [31:0] wd);
		begin
			@(negedge clk);
			hsel = 1'b1;
			htrans = 2'h2;
			hwrite = w;
			haddr = a;
			@(negedge clk);
			hsel = 1'b0;
			htrans = 2'h0;
			hwdata = wd;
			@(negedge clk);
			rdat = hrdata_q;
		end
	endtask
	task rc(input [11:0] a, input [31:0] e);
		begin
			bus(1'b0, a, 32'h0);
			chk(rdat, e);
		end
	endtask
	task quiet;
		chk({31'h0, |{com_q, seg_q}}, 32'h0);
	endtask
	// Falling edges until common 0 rises, bounded
	task rise(output [31:0] c);
		reg pv;
		begin
			c = 0;
			do begin
				pv = com_q[0];
				@(negedge clk);
				c = c + 1;
				if (c == 3000) begin
					n_fail = n_fail + 1;
					print_verdict;
				end
			end while (!(pv === 1'b0 && com_q[0] === 1'b1));
		end
	endtask
	// Settle past a config change, then one full period
	task gap(output [31:0] g);
		begin
			rise(g);
			rise(g);
			rise(g);
		end
	endtask

	// Main sequence
	initial begin
		rst_n = 1'b0;
		ds = 1'b0;
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		n_fail = 0;
		n_checks = 0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		rc(`SLD_OFS_IDENT, `SLD_IDENT_VAL);
		bus(1'b1, `SLD_OFS_IDENT, 32'h0);
		rc(`SLD_OFS_IDENT, `SLD_IDENT_VAL);
		rc(`SLD_OFS_DIVIDER, `SLD_DIVIDER_RST);
		rc(`SLD_OFS_CONTROL, 32'h0);
		rc(12'h00C, 32'h0);
		// Every port owns a low and a high data word
		for (p = 0; p < 8; p = p + 1) begin
			bus(1'b1, `SLD_OFS_DATA_LO + (p << 2), 32'h0F0F0F00 + p);
			bus(1'b1, `SLD_OFS_DATA_HI + (p << 2), 32'hF0F0F000 + p);
		end
		for (p = 0; p < 8; p = p + 1) begin
			rc(`SLD_OFS_DATA_LO + (p << 2), 32'h0F0F0F00 + p);
			rc(`SLD_OFS_DATA_HI + (p << 2), 32'hF0F0F000 + p);
		end
		// Fast correlation, one common, dead time of three ticks
		bus(1'b1, `SLD_OFS_DATA_LO, 32'h00000001);
		bus(1'b1, `SLD_OFS_DIVIDER, 32'h00030005);
		bus(1'b1, `SLD_OFS_CONTROL, 32'h00000120);
		rc(`SLD_OFS_DIVIDER, 32'h00030005);
		rc(`SLD_OFS_CONTROL, 32'h00000120);
		gap(n);
		chk(n, 4 * (5 + 1) + 3);
		b = n_both;
		d = n_diff;
		repeat (54) @(negedge clk);
		chk(n_both - b, 2 * 3);
		chk(n_diff - d, 0);
		// Type B doubles the frame
		bus(1'b1, `SLD_OFS_DIVIDER, 32'h00000005);
		bus(1'b1, `SLD_OFS_CONTROL, 32'h00000121);
		gap(n);
		chk(n, 2 * 4 * (5 + 1));
		// PWM over two commons keeps half duty at every bias
		bus(1'b1, `SLD_OFS_DIVIDER, 32'h0000000B);
		for (p = 0; p < 3; p = p + 1) begin
			bus(1'b1, `SLD_OFS_CONTROL, 32'h00000112 + (p << 6));
			repeat (200) @(negedge clk);
			b = n_ones;
			repeat (192) @(negedge clk);
			chk(n_ones - b, 96);
		end
		// Quarter bias is refused on the slow generator
		bus(1'b1, `SLD_OFS_CONTROL, 32'h00000092);
		repeat (300) @(negedge clk);
		quiet;
		// Slow generator sees only the low divider byte, runs in deep sleep
		bus(1'b1, `SLD_OFS_DIVIDER, 32'h00000100);
		bus(1'b1, `SLD_OFS_CONTROL, 32'h00000020);
		gap(n);
		chk(n, 4 * 20);
		ds = 1'b1;
		gap(n);
		chk(n, 4 * 20);
		ds = 1'b0;
		// Fast generator has the wide counter and stops in deep sleep
		bus(1'b1, `SLD_OFS_CONTROL, 32'h00000120);
		gap(n);
		chk(n, 4 * (256 + 1));
		ds = 1'b1;
		repeat (20) @(negedge clk);
		quiet;
		ds = 1'b0;
		// Off mode applies at the running frame's end, then pins go low
		bus(1'b1, `SLD_OFS_CONTROL, 32'h0);
		repeat (1250) @(negedge clk);
		quiet;
		print_verdict;
	end
endmodule // segment_lcd_direct_drive_test
